//--- tb/serial_peer.sv
// Remote serial peer that samples frames off the transmit line
`timescale 1ns/1ps
module serial_peer (
  input wire logic clock,
  input wire logic line_in,
  input var int bit_clks,
  input var int nbits,
  output logic line_out,
  output logic [11:0] frame,
  output int count
);
  // Mid-bit sampling from each falling edge; NBA keeps the bench free of races
  initial begin
    line_out = 1'b1; // Receive line idles high, nothing sent back
    count = 0;
    forever begin
      @(negedge line_in);
      frame <= '1;
      repeat (bit_clks / 2) @(posedge clock);
      for (int i = 0; i < nbits; i++) begin
        if (i > 0) repeat (bit_clks) @(posedge clock);
        frame[i] <= line_in;
      end
      count <= count + 1;
    end
  end
endmodule : serial_peer

//--- tb/serial_tx_path_frame_format_asserts.sv
// Concurrent checks on bus answers and the transmit line
`timescale 1ns/1ps
module serial_tx_path_frame_format_asserts
  import serial_unit_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic standby,
  input wire serial_unit_pkg::axil_req_s bus_req,
  input wire serial_unit_pkg::axil_rsp_s bus_rsp,
  input wire logic serial_rx_pin,
  input wire logic serial_tx_pin
);
  logic wr_take;
  logic rd_take;
  logic rd_bad;
  logic wr_bad;
  // Handshakes and out-of-map decodes
  assign wr_take = bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready;
  assign rd_take = bus_req.arvalid && bus_rsp.arready;
  assign rd_bad = bus_req.araddr[7:2] > 6'h05;
  assign wr_bad = bus_req.awaddr[7:2] > 6'h05;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_write_answer: assert property (wr_take |=> !bus_rsp.bvalid ##1 bus_rsp.bvalid)
    else $error("write answer late or early");
  a_read_answer: assert property (rd_take |=> bus_rsp.rvalid)
    else $error("read answer late");
  a_b_release: assert property (bus_rsp.bvalid && bus_req.bready |=> !bus_rsp.bvalid && bus_rsp.awready)
    else $error("write response not released");
  a_aw_blocked: assert property (bus_rsp.bvalid |-> !bus_rsp.awready && !bus_rsp.wready)
    else $error("write accepted while answer pending");
  a_ar_blocked: assert property (bus_rsp.rvalid |-> !bus_rsp.arready)
    else $error("read accepted while answer pending");
  a_upper_zero: assert property (bus_rsp.rvalid |-> bus_rsp.rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_read_unmapped: assert property (rd_take && rd_bad |=> bus_rsp.rresp == RESP_SLVERR && bus_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  a_read_mapped: assert property (rd_take && !rd_bad |=> bus_rsp.rresp == RESP_OKAY)
    else $error("mapped read refused");
  a_write_unmapped: assert property (wr_take && wr_bad |-> ##2 bus_rsp.bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_standby_idle: assert property (standby [*3] |-> serial_tx_pin)
    else $error("line not idle in standby");
endmodule : serial_tx_path_frame_format_asserts

//--- tb/tb_serial_tx_path_frame_format.sv
// Bench for the serial unit: register access and transmitted frames
`timescale 1ns/1ps
module tb_serial_tx_path_frame_format;
  import serial_unit_pkg::*;
  localparam int LIMIT = 40000;
  // Sync entries keep the multiprocessor bit clear
  localparam logic [7:0] MODES [9] = '{8'h00, 8'h40, 8'h20, 8'h39, 8'h34, 8'h06, 8'h63, 8'h80, 8'hF8};
  localparam logic [7:0] DATAS [9] = '{8'hB6, 8'hB6, 8'hB6, 8'h36, 8'hF5, 8'h4B, 8'hC5, 8'hB6, 8'h5A};
  localparam int DIVS [4] = '{1, 2, 16, 64};
  logic clock;
  logic reset_n;
  logic standby;
  axil_req_s req;
  axil_rsp_s rsp;
  logic rx_line;
  logic tx_line;
  int bit_clks;
  int nbits;
  logic [11:0] peer_frame;
  int peer_count;
  int err_count;
  int samples_checked;
  int cycles;
  logic [7:0] rd;
  logic [1:0] rr;

  serial_tx_path_frame_format i_serial_tx_path_frame_format (
    .clock(clock),
    .reset_n(reset_n),
    .standby(standby),
    .bus_req(req),
    .bus_rsp(rsp),
    .serial_rx_pin(rx_line),
    .serial_tx_pin(tx_line)
  );

  serial_peer i_serial_peer (
    .clock(clock),
    .line_in(tx_line),
    .bit_clks(bit_clks),
    .nbits(nbits),
    .line_out(rx_line),
    .frame(peer_frame),
    .count(peer_count)
  );

  always #10 clock = ~clock;

  // Hang guard, sized for the slowest baud source
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Address and data offered together, each dropped once taken
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    r = rsp.bresp;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata[7:0];
    r = rsp.rresp;
  endtask : read_reg

  task automatic wait_frame(input int c0, output int w);
    w = 0;
    while (peer_count == c0) begin
      @(posedge clock);
      w++;
    end
  endtask : wait_frame

  // Expected line bits, first bit in bit 0; n gets the frame length
  function automatic logic [11:0] frame_of(input logic [7:0] m, input logic [7:0] d, output int n);
    logic [11:0] f;
    int len;
    f = '1;
    if (m[MODE_COM]) begin
      f[7:0] = d;
      n = 8;
      return f;
    end
    len = (m[MODE_PE] && m[MODE_MP]) ? 5 : (m[MODE_CHR] ? 7 : 8);
    f[0] = 1'b0;
    for (int i = 0; i < len; i++) f[i + 1] = d[i];
    n = len + 1;
    // Multiprocessor bit sent is zero since the control word keeps it clear
    if (m[MODE_PE] || m[MODE_MP]) begin
      f[n] = m[MODE_PE] ? (^(d & 8'(255 >> (8 - len))) ^ m[MODE_PM]) : 1'b0;
      n++;
    end
    n = n + 1 + int'(m[MODE_STOP]);
    return f;
  endfunction : frame_of

  initial begin
    int c;
    int n;
    int w;
    logic [11:0] f;
    clock = 1'b0;
    reset_n = 1'b0;
    standby = 1'b0;
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    bit_clks = 16;
    nbits = 10;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    // Reset values and refused addresses
    read_reg(OFS_MODE, rd, rr);
    check("mode reset", 16'h00, 16'(rd));
    read_reg(OFS_TDR, rd, rr);
    check("buffer reset", 16'hFF, 16'(rd));
    read_reg(8'h18, rd, rr);
    check("unmapped read", 16'(RESP_SLVERR), 16'(rr));
    write_reg(8'h1C, 8'h55, rr);
    check("unmapped write", 16'(RESP_SLVERR), 16'(rr));
    // Transmit enabled with nothing written must stay quiet
    write_reg(OFS_BRATE, 8'h00, rr);
    write_reg(OFS_CTRL, 8'h20, rr);
    repeat (400) @(posedge clock);
    check("idle count", 16'h0, 16'(peer_count));
    check("idle line", 16'h1, 16'(tx_line));
    // Nine frame formats, and each of the four baud sources at least once
    for (int i = 0; i < 9; i++) begin
      write_reg(OFS_MODE, MODES[i], rr);
      f = frame_of(MODES[i], DATAS[i], n);
      nbits = n;
      bit_clks = 16 * DIVS[MODES[i][1:0]];
      c = peer_count;
      write_reg(OFS_TDR, DATAS[i], rr);
      read_reg(OFS_TDR, rd, rr);
      check("buffer readback", 16'(DATAS[i]), 16'(rd));
      wait_frame(c, w);
      check("frame", 16'(f), 16'(peer_frame));
      read_reg(OFS_STAT, rd, rr);
      check("empty flag", 16'h1, 16'(rd[ST_TX_BUFFER_EMPTY_FLAG]));
      repeat (2 * bit_clks) @(posedge clock);
    end
    // Second byte written while the first shifts out
    write_reg(OFS_MODE, 8'h00, rr);
    nbits = 10;
    bit_clks = 16;
    c = peer_count;
    write_reg(OFS_TDR, 8'h81, rr);
    write_reg(OFS_TDR, 8'h7E, rr);
    wait_frame(c, w);
    f = frame_of(8'h00, 8'h81, n);
    check("first frame", 16'(f), 16'(peer_frame));
    wait_frame(c + 1, w);
    check("frame spacing", 16'h00A0, 16'(w));
    f = frame_of(8'h00, 8'h7E, n);
    check("second frame", 16'(f), 16'(peer_frame));
    repeat (400) @(posedge clock);
    check("no resend", 16'(c + 2), 16'(peer_count));
    // Standby in mid-frame idles the line and restores mode, buffer and empty flag to their reset values
    write_reg(OFS_MODE, 8'h48, rr);
    write_reg(OFS_TDR, 8'h00, rr);
    repeat (40) @(posedge clock);
    standby <= 1'b1;
    repeat (4) @(posedge clock);
    check("standby line", 16'h1, 16'(tx_line));
    standby <= 1'b0;
    read_reg(OFS_MODE, rd, rr);
    check("mode standby", 16'h00, 16'(rd));
    read_reg(OFS_TDR, rd, rr);
    check("buffer standby", 16'hFF, 16'(rd));
    read_reg(OFS_STAT, rd, rr);
    check("empty standby", 16'h1, 16'(rd[ST_TX_BUFFER_EMPTY_FLAG]));
    give_verdict();
  end
endmodule : tb_serial_tx_path_frame_format

bind serial_tx_path_frame_format serial_tx_path_frame_format_asserts i_serial_tx_path_frame_format_asserts (
  .clock(clock),
  .reset_n(reset_n),
  .standby(standby),
  .bus_req(bus_req),
  .bus_rsp(bus_rsp),
  .serial_rx_pin(serial_rx_pin),
  .serial_tx_pin(serial_tx_pin)
);

//--- verilog/serial_tx_path_frame_format.sv
// Dual-mode serial unit: transmit path, frame format, small receiver and register slave
`timescale 1ns/1ps

// Summary of operation
// - Shift register sends each character on the transmit pin, bit 0 first.
// - After a character ends, a waiting buffered byte is loaded and sent at once.
// - No load from the buffer while the buffer-empty flag is 1.
// - Shift register is invisible to software, filled only from the buffer.
// - 8-bit transmit buffer, always accessible, all ones on reset and standby.
// - 8-bit mode register, always accessible, zero on reset and standby.
// - Mode bit 7: 0 asynchronous, 1 clocked synchronous.
// - Bit 6 picks 8 or 7 data bits in async; sync is always 8.
// - 7-bit characters drop buffer bit 7.
// - Parity-enable plus multiprocessor gives 5-bit characters, dropping bits 7 to 5.
// - Bit 5 adds and checks parity in async only.
// - Bit 4 picks even or odd parity, only when parity applies.
// - Parity makes data plus parity ones even or odd; receiver checks the same.
// - Bit 3 appends one or two high stop bits in async; none in sync.
// - Receiver checks the first stop bit only; a following low is a new start.
// - Bit 2 enables multiprocessor function, async only.
// - Bits 1 and 0 pick baud source: clock, /2, /16 or /64.
module serial_tx_path_frame_format (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic standby,
  input wire serial_unit_pkg::axil_req_s bus_req,
  output serial_unit_pkg::axil_rsp_s bus_rsp,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin
);
  import serial_unit_pkg::*;

  logic [7:0] mode_q, brate_q, ctrl_q, tdr_q, rdr_q;
  logic tx_buffer_empty_flag_q, tend_q, rdrf_q, oer_q, fer_q, per_q, mpb_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, rdata_d;
  logic [ADDR_W-1:0] waddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic [5:0] pre_q;
  logic [7:0] brc_q;
  tx_state_e tx_q, tx_d;
  logic frame_end;
  logic [3:0] tph_q, rph_q;
  logic [2:0] tbit_q, rbit_q, tx_last_q;
  logic [7:0] tsr_q, rsr_q;
  logic tx_extra_q, tx_has_extra_q, tx_two_q, tx_sync_q, txd_q;
  rx_state_e rx_q;
  logic rx_s1_q, rx_s2_q, rx_extra_q;

  // Bus handshakes
  wire aw_hs = bus_req.awvalid && awready_q;
  wire w_hs = bus_req.wvalid && wready_q;
  wire ar_hs = bus_req.arvalid && arready_q;
  wire b_hs = bvalid_q && bus_req.bready;
  wire r_hs = rvalid_q && bus_req.rready;
  // Both halves of a write held, answer not yet given
  wire do_write = !awready_q && !wready_q && !bvalid_q;

  // Write decode on the held address
  wire [5:0] widx = waddr_q[ADDR_W-1:2];
  wire wr_mode = do_write && wlane_q && widx == OFS_MODE[7:2];
  wire wr_brate = do_write && wlane_q && widx == OFS_BRATE[7:2];
  wire wr_ctrl = do_write && wlane_q && widx == OFS_CTRL[7:2];
  wire wr_tdr = do_write && wlane_q && widx == OFS_TDR[7:2];
  wire wr_stat = do_write && wlane_q && widx == OFS_STAT[7:2];
  wire w_mapped = widx == OFS_MODE[7:2] || widx == OFS_BRATE[7:2] || widx == OFS_CTRL[7:2]
    || widx == OFS_TDR[7:2] || widx == OFS_STAT[7:2] || widx == OFS_RDR[7:2];
  wire [5:0] ridx = bus_req.araddr[ADDR_W-1:2];
  wire rd_rdr = ar_hs && ridx == OFS_RDR[7:2];

  // Frame format selected by the mode register
  wire fmt_sync = mode_q[MODE_COM];
  wire fmt_par = !fmt_sync && mode_q[MODE_PE];
  wire fmt_mp = !fmt_sync && mode_q[MODE_MP];
  wire fmt_five = fmt_par && fmt_mp;
  wire fmt_two = mode_q[MODE_STOP];
  wire fmt_odd = mode_q[MODE_PM];
  wire [2:0] fmt_last = fmt_sync ? LAST_8 : fmt_five ? LAST_5 : mode_q[MODE_CHR] ? LAST_7 : LAST_8;
  wire [7:0] fmt_mask = 8'hFF >> (LAST_8 - fmt_last);
  wire [7:0] tx_data = tdr_q & fmt_mask;
  wire tx_parity = (^tx_data) ^ fmt_odd;
  // Multiprocessor bit takes the parity slot unless parity is also on
  wire tx_extra = (fmt_mp && !fmt_par) ? ctrl_q[CTRL_MPBT] : tx_parity;

  // Baud source prescale and bit-rate divider give the oversample tick
  wire [1:0] cks = {mode_q[MODE_CKS_HI], mode_q[MODE_CKS_LO]};
  wire pre_tick = cks == CKS_DIV1 ? 1'b1 : cks == CKS_DIV2 ? pre_q[0] : cks == CKS_DIV16 ? &pre_q[3:0] : &pre_q;
  wire os_tick = pre_tick && brc_q == 8'h00;
  wire tbit_end = os_tick && tph_q == OS_LAST;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 6'h00;
      brc_q <= RST_BRATE;
    end else begin
      pre_q <= pre_q + 6'h01;
      if (pre_tick) brc_q <= (brc_q == 8'h00) ? brate_q : brc_q - 8'h01;
    end
  end

  // Load only with a byte waiting; a write in flight defers the load one cycle
  wire tx_load_ok = ctrl_q[CTRL_TE] && !tx_buffer_empty_flag_q && !wr_tdr && !standby;

  // Transmit sequencer
  always_comb begin
    tx_d = tx_q;
    frame_end = 1'b0;
    case (tx_q)
      TX_IDLE: if (tx_load_ok) tx_d = fmt_sync ? TX_DATA : TX_START;
      TX_START: if (tbit_end) tx_d = TX_DATA;
      TX_DATA: if (tbit_end && tbit_q == tx_last_q) begin
        if (tx_sync_q) frame_end = 1'b1;
        else tx_d = tx_has_extra_q ? TX_EXTRA : TX_STOP1;
      end
      TX_EXTRA: if (tbit_end) tx_d = TX_STOP1;
      TX_STOP1: if (tbit_end) begin
        if (tx_two_q) tx_d = TX_STOP2;
        else frame_end = 1'b1;
      end
      TX_STOP2: if (tbit_end) frame_end = 1'b1;
      default: tx_d = TX_IDLE;
    endcase
    // Chain straight into the next waiting byte
    if (frame_end) tx_d = tx_load_ok ? (fmt_sync ? TX_DATA : TX_START) : TX_IDLE;
  end
  wire tx_load = (tx_q == TX_IDLE || frame_end) && tx_load_ok;

  // Pin level per state; one cycle behind the state, same for every bit
  wire txd_d = tx_q == TX_START ? 1'b0 : tx_q == TX_DATA ? tsr_q[0] : tx_q == TX_EXTRA ? tx_extra_q : 1'b1;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_q <= TX_IDLE;
      tph_q <= 4'h0;
      tbit_q <= 3'h0;
      tsr_q <= 8'h00;
      tx_last_q <= LAST_8;
      {tx_extra_q, tx_has_extra_q, tx_two_q, tx_sync_q} <= 4'h0;
      txd_q <= 1'b1;
    end else if (standby) begin
      tx_q <= TX_IDLE;
      txd_q <= 1'b1;
    end else begin
      tx_q <= tx_d;
      txd_q <= txd_d;
      if (tx_load) begin
        tsr_q <= tx_data;
        tph_q <= 4'h0;
        tbit_q <= 3'h0;
        tx_last_q <= fmt_last;
        tx_extra_q <= tx_extra;
        tx_has_extra_q <= fmt_par || fmt_mp;
        tx_two_q <= fmt_two && !fmt_sync;
        tx_sync_q <= fmt_sync;
      end else if (tx_q != TX_IDLE && os_tick) begin
        tph_q <= tph_q + 4'h1;
        if (tbit_end && tx_q == TX_DATA) begin
          tsr_q <= {1'b0, tsr_q[7:1]};
          tbit_q <= tbit_q + 3'h1;
        end
      end
    end
  end

  // Receive pin synchroniser
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= serial_rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Async receiver; sync reception needs the clock pin, so it stays idle there
  wire rx_go = rx_q == RX_IDLE && ctrl_q[CTRL_RE] && !fmt_sync && !rx_s2_q;
  wire rx_mid = os_tick && rph_q == OS_MID;
  wire rx_samp = os_tick && rph_q == OS_LAST;
  wire rx_done = rx_q == RX_STOP && rx_samp;
  wire rx_par_bad = fmt_par && ((^(rsr_q & fmt_mask)) ^ rx_extra_q ^ fmt_odd);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_q <= RX_IDLE;
      rph_q <= 4'h0;
      rbit_q <= 3'h0;
      rsr_q <= 8'h00;
      rx_extra_q <= 1'b0;
    end else if (standby) begin
      rx_q <= RX_IDLE;
    end else begin
      if (rx_q != RX_IDLE && os_tick) rph_q <= rph_q + 4'h1;
      case (rx_q)
        RX_IDLE: if (rx_go) begin
          rx_q <= RX_START;
          rph_q <= 4'h0;
          rsr_q <= 8'h00;
          rbit_q <= 3'h0;
        end
        RX_START: if (rx_mid) begin
          rx_q <= rx_s2_q ? RX_IDLE : RX_DATA;
          rph_q <= 4'h0;
        end
        RX_DATA: if (rx_samp) begin
          rsr_q[rbit_q] <= rx_s2_q;
          rbit_q <= rbit_q + 3'h1;
          if (rbit_q == fmt_last) rx_q <= (fmt_par || fmt_mp) ? RX_EXTRA : RX_STOP;
        end
        RX_EXTRA: if (rx_samp) begin
          rx_extra_q <= rx_s2_q;
          rx_q <= RX_STOP;
        end
        // Only the first stop bit is looked at
        RX_STOP: if (rx_samp) rx_q <= RX_IDLE;
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  // Software registers; standby restores the initial values of mode and transmit buffer, not bit rate or control
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= RST_MODE;
      tdr_q <= RST_TDR;
      brate_q <= RST_BRATE;
      ctrl_q <= RST_CTRL;
    end else if (standby) begin
      mode_q <= RST_MODE;
      tdr_q <= RST_TDR;
    end else begin
      if (wr_mode) mode_q <= wdata_q;
      if (wr_tdr) tdr_q <= wdata_q;
      if (wr_brate) brate_q <= wdata_q;
      if (wr_ctrl) ctrl_q <= wdata_q;
    end
  end

  // Status flags; hardware set wins over software clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_buffer_empty_flag_q <= 1'b1;
      tend_q <= 1'b1;
      {rdrf_q, oer_q, fer_q, per_q, mpb_q} <= 5'h00;
      rdr_q <= RST_RDR;
    end else if (standby) begin
      tx_buffer_empty_flag_q <= 1'b1;
      tend_q <= 1'b1;
    end else begin
      if (tx_load) tx_buffer_empty_flag_q <= 1'b1;
      else if (wr_tdr) tx_buffer_empty_flag_q <= 1'b0;
      if (frame_end && !tx_load) tend_q <= 1'b1;
      else if (wr_tdr || tx_load) tend_q <= 1'b0;
      if (rx_done && !rdrf_q) begin
        rdr_q <= rsr_q;
        mpb_q <= rx_extra_q && fmt_mp && !fmt_par;
      end
      rdrf_q <= (rx_done && !rdrf_q) || (rdrf_q && !rd_rdr);
      oer_q <= (rx_done && rdrf_q) || (oer_q && !(wr_stat && wdata_q[ST_OER]));
      fer_q <= (rx_done && !rx_s2_q) || (fer_q && !(wr_stat && wdata_q[ST_FER]));
      per_q <= (rx_done && rx_par_bad) || (per_q && !(wr_stat && wdata_q[ST_PER]));
    end
  end

  // Read decode; shift register has no address
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (ridx == OFS_MODE[7:2]) rdata_d[7:0] = mode_q;
    else if (ridx == OFS_BRATE[7:2]) rdata_d[7:0] = brate_q;
    else if (ridx == OFS_CTRL[7:2]) rdata_d[7:0] = ctrl_q;
    else if (ridx == OFS_TDR[7:2]) rdata_d[7:0] = tdr_q;
    else if (ridx == OFS_STAT[7:2]) rdata_d[7:0] = {tx_buffer_empty_flag_q, rdrf_q, oer_q, fer_q, per_q, tend_q, mpb_q, 1'b0};
    else if (ridx == OFS_RDR[7:2]) rdata_d[7:0] = rdr_q;
  end
  wire r_mapped = ridx <= OFS_RDR[7:2];

  // Bus slave: address and data held independently, answer after both
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {awready_q, wready_q, arready_q} <= 3'h7;
      {bvalid_q, rvalid_q} <= 2'h0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      waddr_q <= '0;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      if (aw_hs) waddr_q <= bus_req.awaddr;
      if (w_hs) begin
        wdata_q <= bus_req.wdata[7:0];
        wlane_q <= bus_req.wstrb[0];
      end
      awready_q <= aw_hs ? 1'b0 : (b_hs ? 1'b1 : awready_q);
      wready_q <= w_hs ? 1'b0 : (b_hs ? 1'b1 : wready_q);
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (b_hs) bvalid_q <= 1'b0;
      if (ar_hs) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rdata_d;
        rresp_q <= r_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (r_hs) begin
        arready_q <= 1'b1;
        rvalid_q <= 1'b0;
      end
    end
  end

  assign bus_rsp.awready = awready_q;
  assign bus_rsp.wready = wready_q;
  assign bus_rsp.bresp = bresp_q;
  assign bus_rsp.bvalid = bvalid_q;
  assign bus_rsp.arready = arready_q;
  assign bus_rsp.rdata = rdata_q;
  assign bus_rsp.rresp = rresp_q;
  assign bus_rsp.rvalid = rvalid_q;
  assign serial_tx_pin = txd_q;
endmodule : serial_tx_path_frame_format

//--- verilog/serial_unit_pkg.sv
// Register map, field layout, reset values and bus carriers of the serial unit
package serial_unit_pkg;
  localparam int ADDR_W = 8;
  // Byte offsets of the register words
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_BRATE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_TDR = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_RDR = 8'h14;
  // Reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_BRATE = 8'hFF;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_TDR = 8'hFF;
  localparam logic [7:0] RST_RDR = 8'h00;
  // Mode register fields
  localparam int MODE_COM = 7;
  localparam int MODE_CHR = 6;
  localparam int MODE_PE = 5;
  localparam int MODE_PM = 4;
  localparam int MODE_STOP = 3;
  localparam int MODE_MP = 2;
  localparam int MODE_CKS_HI = 1;
  localparam int MODE_CKS_LO = 0;
  // Control register fields
  localparam int CTRL_TE = 5;
  localparam int CTRL_RE = 4;
  localparam int CTRL_MPBT = 0;
  // Status register fields
  localparam int ST_TX_BUFFER_EMPTY_FLAG = 7;
  localparam int ST_RDRF = 6;
  localparam int ST_OER = 5;
  localparam int ST_FER = 4;
  localparam int ST_PER = 3;
  localparam int ST_TEND = 2;
  localparam int ST_MPB = 1;
  // Baud source select codes
  localparam logic [1:0] CKS_DIV1 = 2'h0;
  localparam logic [1:0] CKS_DIV2 = 2'h1;
  localparam logic [1:0] CKS_DIV16 = 2'h2;
  // Index of last data bit per character length
  localparam logic [2:0] LAST_8 = 3'h7;
  localparam logic [2:0] LAST_7 = 3'h6;
  localparam logic [2:0] LAST_5 = 3'h4;
  // Oversample ticks per bit, and the mid point of a start bit
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3, TX_EXTRA = 3'h2, TX_STOP1 = 3'h6, TX_STOP2 = 3'h7
  } tx_state_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3, RX_EXTRA = 3'h2, RX_STOP = 3'h6
  } rx_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_s;
endpackage : serial_unit_pkg
